// ==== rtl/cawt_chan_ctl.sv ====
// System-side channel control: ready and size returns, central arbitration,
// last count, interrupt order, slot select, error, init, refresh and lanes.
// Assumes all inputs are synchronous to I_CLK and already resolved wires.
`timescale 1ns/100ps
`default_nettype none
module cawt_chan_ctl (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_SRST,
  // Slot returns
  input  wire logic [7:0]  I_SLOT_READY,
  input  wire logic [7:0]  I_SLOT_WIDE32_N,
  input  wire logic        I_WIDE16_RETURN_N,
  output logic             O_READY_RETURN,
  output logic             O_WIDE32_RETURN_N,
  // Arbitration
  input  wire logic [3:0]  I_ARB_LEVEL,
  input  wire logic        I_CHAN_REQ_N,
  input  wire logic        I_BLOCK_XFER_N,
  input  wire logic [1:0]  I_CYCLE_STATUS_N,
  input  wire logic        I_CMD_N,
  output logic             O_ARB_OR_GRANT,
  output logic [3:0]       O_ARB_WINNER,
  // DMA last count
  input  wire logic        I_DMA_ACTIVE,
  input  wire logic        I_DMA_COUNT_HIT,
  output logic             O_LAST_COUNT_N,
  output logic             O_LAST_COUNT_OE,
  // Interrupt order
  input  wire logic [15:0] I_IRQ_N,
  output logic             O_IRQ_PEND,
  output logic [3:0]       O_IRQ_LEVEL,
  // Configuration select and fatal error
  input  wire logic        I_CFG_ENABLE,
  input  wire logic [2:0]  I_CFG_SLOT,
  output logic [7:0]       O_SLOT_CONFIG_SELECT_N,
  input  wire logic        I_FATAL_ERROR_N,
  input  wire logic        I_FATAL_CLEAR,
  output logic             O_FATAL_SEEN,
  // Channel init and refresh
  input  wire logic        I_LOW_VOLTAGE,
  input  wire logic        I_PROG_INIT,
  output logic             O_CHANNEL_INIT,
  input  wire logic        I_REFRESH_REQ,
  output logic             O_REFRESH_N,
  output logic [8:0]       O_REFRESH_ADDR,
  // Address and lanes
  input  wire logic        I_ADDR_LATCH_N,
  input  wire logic        I_MEM_IO,
  input  wire logic [31:0] I_ADDR,
  output logic [31:0]      O_DECODE_ADDR,
  input  wire logic        I_TRANSLATE_SELECT,
  input  wire logic        I_BYTE_HIGH_N,
  input  wire logic        I_XFER_START,
  input  wire logic [3:0]  I_MASTER_LANE_N,
  output logic [3:0]       O_LANE_ENABLE_N,
  output logic             O_LANE_ENABLE_OE,
  output logic             O_STEP_VALID,
  output logic [1:0]       O_STEP_UNIT,
  output logic             O_STEP_DONE
);
  cawt_pkg::cawt_arb_type arb_r;
  logic [7:0] arb_cnt_r;
  logic       bus_quiet;
  logic [7:0] init_cnt_r;
  logic [7:0] ref_cnt_r;
  logic       cmd_n_q_r;
  logic       addr_latch_n_q_r;
  logic [3:0] irq_lvl_nxt;
  logic       irq_pend_nxt;
  cawt_xlate_if xl ();

  // Returns: combine per-slot lines, registered for a clean output
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_READY_RETURN    <= 1'b0;
      O_WIDE32_RETURN_N <= 1'b1;
    end else begin
      O_READY_RETURN    <= &I_SLOT_READY;
      O_WIDE32_RETURN_N <= &I_SLOT_WIDE32_N;
    end
  end

  // Central arbitration; contenders resolve the level themselves on the open-collector bus
  assign bus_quiet = I_CYCLE_STATUS_N == cawt_pkg::STATUS_IDLE && I_BLOCK_XFER_N && I_CMD_N;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      arb_r          <= cawt_pkg::ARB_OWNED;
      arb_cnt_r      <= 8'h00;
      O_ARB_OR_GRANT <= 1'b0;
      O_ARB_WINNER   <= cawt_pkg::ARB_LEVEL_RST;
    end else begin
      unique case (arb_r)
        cawt_pkg::ARB_OWNED: begin
          if (!I_CHAN_REQ_N) begin
            arb_r <= cawt_pkg::ARB_WAIT;
          end
        end
        cawt_pkg::ARB_WAIT: begin
          if (bus_quiet) begin
            arb_r          <= cawt_pkg::ARB_SETTLE;
            arb_cnt_r      <= 8'h01;
            O_ARB_OR_GRANT <= 1'b1;
          end
        end
        cawt_pkg::ARB_SETTLE: begin
          if (arb_cnt_r == cawt_pkg::ARB_SETTLE_CYC) begin
            arb_r          <= cawt_pkg::ARB_OWNED;
            O_ARB_OR_GRANT <= 1'b0;
            O_ARB_WINNER   <= I_ARB_LEVEL;
          end else begin
            arb_cnt_r <= arb_cnt_r + 8'h01;
          end
        end
      endcase
    end
  end

  // Last count only while DMA owns the channel and a command is active
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_LAST_COUNT_N  <= 1'b1;
      O_LAST_COUNT_OE <= 1'b0;
    end else begin
      O_LAST_COUNT_OE <= I_DMA_ACTIVE;
      O_LAST_COUNT_N  <= !(I_DMA_ACTIVE && I_DMA_COUNT_HIT && !I_CMD_N);
    end
  end

  // Interrupt order walks the fixed table; first pending level wins
  always_comb begin
    irq_pend_nxt = 1'b0;
    irq_lvl_nxt  = cawt_pkg::IRQ_NONE;
    for (int i = cawt_pkg::N_IRQ_ORDER - 1; i >= 0; i--) begin
      if (!I_IRQ_N[cawt_pkg::IRQ_ORDER[i]]) begin
        irq_pend_nxt = 1'b1;
        irq_lvl_nxt  = cawt_pkg::IRQ_ORDER[i];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_IRQ_PEND  <= 1'b0;
      O_IRQ_LEVEL <= cawt_pkg::IRQ_NONE;
    end else begin
      O_IRQ_PEND  <= irq_pend_nxt;
      O_IRQ_LEVEL <= irq_lvl_nxt;
    end
  end

  // One select per slot; never two at once
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_SLOT_CONFIG_SELECT_N <= 8'hFF;
    end else begin
      O_SLOT_CONFIG_SELECT_N <= I_CFG_ENABLE ? ~(8'h01 << I_CFG_SLOT) : 8'hFF;
    end
  end

  // Set wins over clear so an error in the clearing cycle is kept
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_FATAL_SEEN <= 1'b0;
    end else if (!I_FATAL_ERROR_N) begin
      O_FATAL_SEEN <= 1'b1;
    end else if (I_FATAL_CLEAR) begin
      O_FATAL_SEEN <= 1'b0;
    end
  end

  // Channel init: reset release counts as power on; any trigger restarts the minimum
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      init_cnt_r     <= 8'h00;
      O_CHANNEL_INIT <= 1'b1;
    end else if (I_LOW_VOLTAGE || I_PROG_INIT) begin
      init_cnt_r     <= 8'h00;
      O_CHANNEL_INIT <= 1'b1;
    end else if (init_cnt_r != cawt_pkg::CHAN_INIT_CYC) begin
      init_cnt_r     <= init_cnt_r + 8'h01;
      O_CHANNEL_INIT <= 1'b1;
    end else begin
      O_CHANNEL_INIT <= 1'b0;
    end
  end

  // Refresh: fixed-length read strobe, row advances at its end; not a timebase
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ref_cnt_r      <= 8'h00;
      O_REFRESH_N    <= 1'b1;
      O_REFRESH_ADDR <= cawt_pkg::REFRESH_ADDR_RST;
    end else if (O_REFRESH_N) begin
      if (I_REFRESH_REQ) begin
        O_REFRESH_N <= 1'b0;
        ref_cnt_r   <= 8'h01;
      end
    end else if (ref_cnt_r == cawt_pkg::REFRESH_CYC) begin
      O_REFRESH_N    <= 1'b1;
      O_REFRESH_ADDR <= O_REFRESH_ADDR + 9'h001;
    end else begin
      ref_cnt_r <= ref_cnt_r + 8'h01;
    end
  end

  // Address captured at the latch strobe's leading edge; I/O keeps the low half
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      addr_latch_n_q_r <= 1'b1;
      cmd_n_q_r        <= 1'b1;
      O_DECODE_ADDR    <= 32'h00000000;
    end else begin
      addr_latch_n_q_r <= I_ADDR_LATCH_N;
      cmd_n_q_r        <= I_CMD_N;
      if (addr_latch_n_q_r && !I_ADDR_LATCH_N) begin
        O_DECODE_ADDR <= I_MEM_IO ? I_ADDR : {16'h0000, I_ADDR[15:0]};
      end
    end
  end

  // Translator lanes for narrow masters; contiguous by construction
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_LANE_ENABLE_N  <= cawt_pkg::LANES_NONE;
      O_LANE_ENABLE_OE <= 1'b0;
    end else begin
      O_LANE_ENABLE_OE <= I_TRANSLATE_SELECT;
      if (I_TRANSLATE_SELECT) begin
        O_LANE_ENABLE_N <= I_ADDR[1] ? {I_BYTE_HIGH_N, I_ADDR[0], 2'h3}
                                     : {2'h3, I_BYTE_HIGH_N, I_ADDR[0]};
      end else begin
        O_LANE_ENABLE_N <= cawt_pkg::LANES_NONE;
      end
    end
  end

  // Split steps advance at each command end; size comes from the slot returns
  assign xl.start   = I_XFER_START;
  assign xl.advance = !cmd_n_q_r && I_CMD_N;
  assign xl.be_n    = I_MASTER_LANE_N;
  assign xl.size    = !O_WIDE32_RETURN_N ? cawt_pkg::SZ32 :
                      !I_WIDE16_RETURN_N ? cawt_pkg::SZ16 : cawt_pkg::SZ8;

  cawt_lane_seq u_lane_seq (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .sq     (xl.seq)
  );

  assign O_STEP_VALID = xl.step_valid;
  assign O_STEP_UNIT  = xl.step_unit;
  assign O_STEP_DONE  = xl.step_done;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  sequence arb_start_s;
    arb_r == cawt_pkg::ARB_WAIT && bus_quiet;
  endsequence
  sequence arb_hold_s;
    O_ARB_OR_GRANT [*5] ##1 !O_ARB_OR_GRANT;
  endsequence

  ready_and_a: assert property (!I_SRST |=> O_READY_RETURN == &$past(I_SLOT_READY))
    else $error("ready return is not the AND of slot ready");
  wide_return_a: assert property (!I_SRST |=> O_WIDE32_RETURN_N == &$past(I_SLOT_WIDE32_N))
    else $error("wide return is not the low-active OR");
  grant_rise_a: assert property (arb_start_s |=> $rose(O_ARB_OR_GRANT))
    else $error("grant did not rise on an idle bus");
  grant_settle_a: assert property ($rose(O_ARB_OR_GRANT) |-> arb_hold_s)
    else $error("arbitration window length wrong");
  winner_take_a: assert property ($fell(O_ARB_OR_GRANT) |-> O_ARB_WINNER == $past(I_ARB_LEVEL))
    else $error("winner not taken at grant");
  last_count_a: assert property (!O_LAST_COUNT_N |-> O_LAST_COUNT_OE && !$past(I_CMD_N))
    else $error("last count outside a DMA command");
  irq_order_a: assert property (!I_IRQ_N[9] |=> O_IRQ_PEND && O_IRQ_LEVEL == 4'h9)
    else $error("most urgent interrupt not chosen");
  cfg_select_a: assert property ($countones(~O_SLOT_CONFIG_SELECT_N) <= 1)
    else $error("more than one slot selected");
  fatal_keep_a: assert property (!I_FATAL_ERROR_N |=> O_FATAL_SEEN)
    else $error("fatal error lost");
  init_min_a: assert property ($rose(O_CHANNEL_INIT) |-> O_CHANNEL_INIT [*8])
    else $error("channel init too short");
  io_addr_a: assert property (addr_latch_n_q_r && !I_ADDR_LATCH_N && !I_MEM_IO
      |=> O_DECODE_ADDR[31:16] == 16'h0000)
    else $error("I/O address kept upper bits");
  lane_owner_a: assert property (!$past(I_TRANSLATE_SELECT) |-> !O_LANE_ENABLE_OE
      && O_LANE_ENABLE_N == cawt_pkg::LANES_NONE)
    else $error("translator drove lanes for a wide master");
endmodule
`default_nettype wire

// ==== rtl/cawt_lane_seq.sv ====
// Splits one wide transfer into byte or halfword steps for narrow slaves.
// Assumes start and advance are single-cycle pulses from the top.
`timescale 1ns/100ps
`default_nettype none
module cawt_lane_seq (
  input  wire logic  i_clk,
  input  wire logic  i_srst,
  cawt_xlate_if.seq  sq
);
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic [3:0] units;
  logic       valid_r;
  logic [1:0] unit_r;
  logic       done_r;

  function automatic logic [1:0] low_idx(input logic [3:0] m);
    logic [1:0] k;
    k = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        k = 2'(i);
      end
    end
    return k;
  endfunction

  always_comb begin
    unique case (sq.size)
      cawt_pkg::SZ8:  units = ~sq.be_n;
      cawt_pkg::SZ16: units = {2'h0, ~&sq.be_n[3:2], ~&sq.be_n[1:0]};
      cawt_pkg::SZ32: units = {3'h0, ~&sq.be_n};
      default:        units = 4'h0;
    endcase
  end

  // New starts are ignored until the running split has drained
  always_comb begin
    pend_nxt = pend_r;
    if (sq.start && pend_r == 4'h0) begin
      pend_nxt = units;
    end else if (sq.advance && pend_r != 4'h0) begin
      pend_nxt = pend_r & ~(4'h1 << low_idx(pend_r));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pend_r  <= 4'h0;
      valid_r <= 1'b0;
      unit_r  <= 2'h0;
      done_r  <= 1'b0;
    end else begin
      pend_r  <= pend_nxt;
      valid_r <= pend_nxt != 4'h0;
      unit_r  <= low_idx(pend_nxt);
      done_r  <= pend_r != 4'h0 && pend_nxt == 4'h0;
    end
  end

  assign sq.step_valid = valid_r;
  assign sq.step_unit  = unit_r;
  assign sq.step_done  = done_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence byte_split_s;
    sq.start && pend_r == 4'h0 && sq.size == cawt_pkg::SZ8 && sq.be_n == 4'h0;
  endsequence

  byte_split_four_a: assert property (byte_split_s |=> pend_r == 4'hF && unit_r == 2'h0)
    else $error("byte split did not queue four steps");
  half_split_two_a: assert property (sq.start && pend_r == 4'h0 && sq.size == cawt_pkg::SZ16
      && sq.be_n == 4'h0 |=> pend_r == 4'h3)
    else $error("halfword split did not queue two steps");
  split_done_a: assert property (sq.advance && $onehot(pend_r) |=> done_r && !valid_r)
    else $error("last step did not end the split");
endmodule
`default_nettype wire

// ==== rtl/cawt_pkg.sv ====
// Constants and types for the channel arbitration and wide transfer block.
// Assumes one 50 MHz clock; every time below becomes a cycle count of it.
package cawt_pkg;
  localparam int N_SLOTS       = 8;
  localparam int CLK_NS        = 20;
  localparam int ARB_SETTLE_NS = 100;
  localparam int CHAN_INIT_NS  = 1000;
  localparam int REFRESH_NS    = 200;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] ARB_SETTLE_CYC = 8'(ceil_cyc(ARB_SETTLE_NS));
  localparam logic [7:0] CHAN_INIT_CYC  = 8'(ceil_cyc(CHAN_INIT_NS));
  localparam logic [7:0] REFRESH_CYC    = 8'(ceil_cyc(REFRESH_NS));

  localparam logic [3:0] ARB_LEVEL_RST    = 4'hF;
  localparam logic [8:0] REFRESH_ADDR_RST = 9'h000;
  localparam logic [1:0] STATUS_IDLE      = 2'h3;
  localparam logic [3:0] LANES_NONE       = 4'hF;
  localparam logic [3:0] IRQ_NONE         = 4'h0;
  localparam int         N_IRQ_ORDER      = 11;
  localparam logic [3:0] IRQ_ORDER [N_IRQ_ORDER] =
    '{4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

  typedef enum logic [1:0] {SZ8, SZ16, SZ32} cawt_size_type;
  typedef enum logic [1:0] {ARB_OWNED, ARB_WAIT, ARB_SETTLE} cawt_arb_type;
endpackage

// ==== rtl/cawt_xlate_if.sv ====
// Carrier between the channel control top and its lane sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface cawt_xlate_if;
  logic                   start;
  logic                   advance;
  logic [3:0]             be_n;
  cawt_pkg::cawt_size_type size;
  logic                   step_valid;
  logic [1:0]             step_unit;
  logic                   step_done;
  modport ctl (output start, advance, be_n, size, input step_valid, step_unit, step_done);
  modport seq (input start, advance, be_n, size, output step_valid, step_unit, step_done);
endinterface
`default_nettype wire

// ==== testbench/cawt_adapters.sv ====
// Adapter-side model: two contenders on the shared arbitration lines.
// Assumes grant comes from the channel control on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cawt_adapters (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Contender setup and grant
  input  wire logic       i_grant,
  input  wire logic [1:0] i_want,
  input  wire logic [3:0] i_lvl_a,
  input  wire logic [3:0] i_lvl_b,
  // Shared lines
  output logic [3:0]      o_arb_level,
  output logic            o_chan_req_n,
  output logic            o_block_xfer_n
);
  logic [3:0] a_r;
  logic [3:0] b_r;
  logic [1:0] part_r;
  logic [1:0] blk_r;
  logic       grant_d_r;

  always_ff @(posedge i_clk) begin
    grant_d_r <= i_grant;
    if (i_srst) begin
      part_r         <= 2'h0;
      blk_r          <= 2'h0;
      o_arb_level    <= 4'hF;
      o_chan_req_n   <= 1'b1;
      o_block_xfer_n <= 1'b1;
    end else if (i_grant && !grant_d_r) begin
      a_r         <= i_lvl_a;
      b_r         <= i_lvl_b;
      part_r      <= i_want;
      // Unsettled wired value first, so an early sample picks a wrong code
      o_arb_level <= (i_want[0] ? i_lvl_a : 4'h0) | (i_want[1] ? i_lvl_b : 4'h0);
    end else if (i_grant) begin
      // Request dropped while arbitrating so grant's fall is not read as a new one
      o_chan_req_n <= 1'b1;
      if (part_r == 2'h3)
        o_arb_level <= (a_r < b_r) ? a_r : b_r;
      else
        o_arb_level <= part_r[0] ? a_r : b_r;
    end else if (grant_d_r && part_r != 2'h0) begin
      part_r         <= 2'h0;
      o_chan_req_n   <= 1'b1;
      o_block_xfer_n <= 1'b0;
      blk_r          <= 2'h3;
    end else if (blk_r != 2'h0) begin
      blk_r <= blk_r - 2'h1;
      if (blk_r == 2'h1) begin
        o_block_xfer_n <= 1'b1;
        o_arb_level    <= 4'hF;
      end
    end else begin
      o_chan_req_n <= ~|i_want;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the channel control block and its adapter model.
// Assumes a 50 MHz clock; stimulus moves on rising edges only.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, srst = 1'b1;
  logic        w16_n = 1'b1, cmd_n = 1'b1, dma_act = 1'b0, dma_hit = 1'b0, cfg_en = 1'b0;
  logic        fatal_n = 1'b1, fatal_clr = 1'b0, low_v = 1'b0, prog_init = 1'b0;
  logic        ref_req = 1'b0, adl_n = 1'b1, mem_io = 1'b1, xlate = 1'b0, bhe_n = 1'b1;
  logic        xstart = 1'b0;
  logic [1:0]  cyc_st_n = 2'h3, want = 2'h0;
  logic [2:0]  cfg_slot = 3'h0;
  logic [3:0]  mlane_n = 4'hF, lvl_a = 4'hF, lvl_b = 4'hF;
  logic [7:0]  slot_ready = 8'hFF, slot_w32_n = 8'hFF;
  logic [15:0] irq_n = 16'hFFFF;
  logic [31:0] addr = 32'h0;
  logic        req_n, blk_n, ready_ret, w32_ret_n, grant, lc_n, lc_oe, irq_pend;
  logic        fatal_seen, ch_init, ref_n, lane_oe, st_valid, st_done;
  logic [1:0]  st_unit;
  logic [3:0]  arb_level, winner, irq_lvl, lane_n;
  logic [7:0]  sel_n;
  logic [8:0]  ref_addr;
  logic [31:0] dec_addr;
  int          num_errors = 0, comparisons = 0, cycles = 0;

  always #10 clk = ~clk;

  cawt_chan_ctl uut (
    .I_CLK(clk), .I_SRST(srst), .I_SLOT_READY(slot_ready), .I_SLOT_WIDE32_N(slot_w32_n),
    .I_WIDE16_RETURN_N(w16_n), .O_READY_RETURN(ready_ret), .O_WIDE32_RETURN_N(w32_ret_n),
    .I_ARB_LEVEL(arb_level), .I_CHAN_REQ_N(req_n), .I_BLOCK_XFER_N(blk_n),
    .I_CYCLE_STATUS_N(cyc_st_n), .I_CMD_N(cmd_n), .O_ARB_OR_GRANT(grant), .O_ARB_WINNER(winner),
    .I_DMA_ACTIVE(dma_act), .I_DMA_COUNT_HIT(dma_hit), .O_LAST_COUNT_N(lc_n),
    .O_LAST_COUNT_OE(lc_oe), .I_IRQ_N(irq_n), .O_IRQ_PEND(irq_pend), .O_IRQ_LEVEL(irq_lvl),
    .I_CFG_ENABLE(cfg_en), .I_CFG_SLOT(cfg_slot), .O_SLOT_CONFIG_SELECT_N(sel_n),
    .I_FATAL_ERROR_N(fatal_n), .I_FATAL_CLEAR(fatal_clr), .O_FATAL_SEEN(fatal_seen),
    .I_LOW_VOLTAGE(low_v), .I_PROG_INIT(prog_init), .O_CHANNEL_INIT(ch_init),
    .I_REFRESH_REQ(ref_req), .O_REFRESH_N(ref_n), .O_REFRESH_ADDR(ref_addr),
    .I_ADDR_LATCH_N(adl_n), .I_MEM_IO(mem_io), .I_ADDR(addr), .O_DECODE_ADDR(dec_addr),
    .I_TRANSLATE_SELECT(xlate), .I_BYTE_HIGH_N(bhe_n), .I_XFER_START(xstart),
    .I_MASTER_LANE_N(mlane_n), .O_LANE_ENABLE_N(lane_n), .O_LANE_ENABLE_OE(lane_oe),
    .O_STEP_VALID(st_valid), .O_STEP_UNIT(st_unit), .O_STEP_DONE(st_done));

  cawt_adapters partner (
    .i_clk(clk), .i_srst(srst), .i_grant(grant), .i_want(want), .i_lvl_a(lvl_a),
    .i_lvl_b(lvl_b), .o_arb_level(arb_level), .o_chan_req_n(req_n), .o_block_xfer_n(blk_n));

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Lets the edge's updates land before anything is sampled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_arb(input logic [3:0] a, input logic [3:0] b, input logic [3:0] e);
    int n;
    @(posedge clk) begin
      lvl_a <= a;
      lvl_b <= b;
      want     <= 2'h3;
      cmd_n    <= 1'b0;
      cyc_st_n <= 2'h2;
    end
    step(6);
    chk(grant, 1'b0);
    @(posedge clk) cmd_n <= 1'b1;
    step(3);
    chk(grant, 1'b0);
    @(posedge clk) cyc_st_n <= 2'h3;
    n = 0;
    while (grant !== 1'b1 && n < 6) begin
      step(1);
      n++;
    end
    chk(grant, 1'b1);
    n = 0;
    while (grant === 1'b1 && n < 20) begin
      n++;
      step(1);
    end
    chk(n, int'(cawt_pkg::ARB_SETTLE_CYC));
    chk(winner, e);
    @(posedge clk) want <= 2'h0;
    step(8);
  endtask

  task automatic t_split(input logic w16, input int units);
    int n;
    @(posedge clk) w16_n <= w16;
    @(posedge clk) begin
      mlane_n <= 4'h0;
      xstart  <= 1'b1;
    end
    @(posedge clk) xstart <= 1'b0;
    step(2);
    chk(st_valid, 1'b1);
    for (int u = 0; u < units; u++) begin
      chk(st_unit, u);
      @(posedge clk) cmd_n <= 1'b0;
      @(posedge clk) cmd_n <= 1'b1;
      if (u + 1 < units) begin
        step(3);
      end else begin
        n = 0;
        while (st_done !== 1'b1 && n < 6) begin
          step(1);
          n++;
        end
        chk(st_done, 1'b1);
        chk(st_valid, 1'b0);
      end
    end
  endtask

  task automatic t_misc();
    logic [3:0]  ord [11] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [15:0] m;
    logic [3:0]  e;
    int          n;
    for (int s = 0; s < 9; s++) begin
      @(posedge clk) begin
        slot_ready <= 8'(~(9'h001 << s));
        slot_w32_n <= 8'(~(9'h001 << s));
        cfg_en     <= (s < 8);
        cfg_slot   <= s[2:0];
      end
      step(2);
      chk(ready_ret, s == 8);
      chk(w32_ret_n, s == 8);
      chk(sel_n, (s < 8) ? 8'(~(8'h01 << s)) : 8'hFF);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) {dma_act, dma_hit, cmd_n} <= k[2:0];
      step(2);
      chk(lc_oe, k[2]);
      chk(lc_n, k != 6);
    end
    @(posedge clk) begin
      {dma_act, dma_hit} <= 2'h0;
      irq_n              <= 16'hDEF8;
    end
    step(2);
    chk(irq_pend, 1'b0);
    m = 16'hFFFF;
    for (int k = 10; k >= 0; k--) begin
      m[ord[k]] = 1'b0;
      @(posedge clk) irq_n <= m & 16'hDEF8;
      step(2);
      chk({irq_pend, irq_lvl}, {1'b1, ord[k]});
    end
    @(posedge clk) fatal_n <= 1'b0;
    @(posedge clk) fatal_n <= 1'b1;
    step(5);
    chk(fatal_seen, 1'b1);
    @(posedge clk) fatal_clr <= 1'b1;
    @(posedge clk) fatal_clr <= 1'b0;
    step(1);
    chk(fatal_seen, 1'b0);
    // Error and clear in one cycle: the error must be kept
    @(posedge clk) {fatal_n, fatal_clr} <= 2'b01;
    @(posedge clk) {fatal_n, fatal_clr} <= 2'b10;
    step(1);
    chk(fatal_seen, 1'b1);
    @(posedge clk) ref_req <= 1'b1;
    @(posedge clk) ref_req <= 1'b0;
    step(0);
    n = 0;
    while (ref_n !== 1'b0 && n < 4) begin
      step(1);
      n++;
    end
    n = 0;
    while (ref_n === 1'b0 && n < 30) begin
      n++;
      step(1);
    end
    chk(n, int'(cawt_pkg::REFRESH_CYC));
    step(1);
    chk(ref_addr, 9'h001);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) begin
        mem_io <= !k[0];
        addr   <= 32'hA5C3_9E71;
        adl_n  <= 1'b0;
      end
      @(posedge clk) adl_n <= 1'b1;
      step(2);
      chk(dec_addr, k[0] ? 32'h0000_9E71 : 32'hA5C3_9E71);
    end
    for (int v = 0; v < 9; v++) begin
      @(posedge clk) begin
        xlate <= (v < 8);
        addr  <= 32'(v[1:0]);
        bhe_n <= v[2];
      end
      e = v[1] ? {v[2], v[0], 2'b11} : {2'b11, v[2], v[0]};
      step(2);
      chk(lane_n, (v < 8) ? e : 4'hF);
      chk(lane_oe, v < 8);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    step(1);
    chk({grant, winner, lc_oe, fatal_seen, ref_n}, {1'b0, 4'hF, 1'b0, 1'b0, 1'b1});
    chk(ch_init, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) {low_v, prog_init} <= k[0] ? 2'b10 : 2'b01;
      @(posedge clk) {low_v, prog_init} <= 2'b00;
      step(int'(cawt_pkg::CHAN_INIT_CYC) - 5);
      chk(ch_init, 1'b1);
      step(10);
      chk(ch_init, 1'b0);
    end
    t_arb(4'h5, 4'h3, 4'h3);
    t_arb(4'h0, 4'hF, 4'h0);
    t_arb(4'hE, 4'hF, 4'hE);
    t_misc();
    t_split(1'b1, 4);
    t_split(1'b0, 2);
    conclude();
  end
endmodule
`default_nettype wire
